/* hw/sfci_top.sv */
// Device side of a serial flash command interface: pin decoder, status, page buffer.
// Assumes the array sits outside on ref_clk_i and answers arr_addr_o within two cycles.
`timescale 1ns/1ns
`include "sfci_params.svh"
module sfci_top #(
  parameter int unsigned ERASE_CYC = `SFCI_ERASE_MS * `SFCI_CLK_KHZ,
  parameter int unsigned PROG_CYC = `SFCI_PROG_MS * `SFCI_CLK_KHZ
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Array read port
  output logic [20:0] arr_addr_o,
  input wire logic [7:0] arr_data_i,
  // Program and erase sequencer
  output logic op_start_o,
  output sfci_pkg::sfci_act_t op_kind_o,
  output logic [20:0] op_addr_o,
  output logic [7:0] op_len_o,
  input wire logic op_fail_i,
  input wire logic [6:0] pbuf_idx_i,
  output logic [7:0] pbuf_byte_o,
  // Status view
  output logic [7:0] status_o
);
  import sfci_pkg::*;

  logic [2:0] pins_s;
  logic cs_q, sclk_q;
  sfci_state_t st_q, st_d;
  sfci_act_t act_q;
  logic [2:0] cnt_q, bidx_q;
  logic [7:0] in_sh_q, out_sh_q, op_q;
  logic [11:0] seg_q;
  logic [8:0] ctr_q;
  logic [7:0] pbuf_q [128];
  logic [7:0] pcnt_q;
  logic id_sel_q, busy_q, cmpl_q, eerr_q, perr_q;
  logic [31:0] tmr_q;

  // Pin levels cross into ref_clk_i before anything reads them
  sfci_sync #(.W(3), .RST(3'h4)) u_sync (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i({cs_n_i, sclk_i, si_i}),
    .q_o(pins_s)
  );

  wire cs_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire si_s = pins_s[0];
  wire rise = sclk_s & ~sclk_q & ~cs_s;
  wire cs_fall = ~cs_s & cs_q;
  wire cs_rise = cs_s & ~cs_q;
  wire byte_done = rise & (cnt_q == 3'h7);
  wire [7:0] in_byte = {in_sh_q[6:0], si_s};
  wire in_cmd = byte_done & (st_q == SFCI_CMD);
  wire clear_cmd = in_cmd & (in_byte == `SFCI_OP_CLR);
  wire out_st = (st_q == SFCI_ARR) | (st_q == SFCI_STAT) | (st_q == SFCI_IDOUT);
  wire addr_last = byte_done & (st_q == SFCI_ADDR) &
                   (bidx_q == ((op_q == `SFCI_OP_SECT) ? `SFCI_SECT_BYTES - 3'h1
                                                      : `SFCI_ADDR_BYTES - 3'h1));
  wire dummy_last = byte_done & (st_q == SFCI_DUMMY) &
                    (bidx_q == ((op_q == `SFCI_OP_ID) ? `SFCI_ID_DUMMY - 3'h1
                                                     : `SFCI_RD_DUMMY - 3'h1));
  // Reserved bits read as zero
  wire [7:0] status = {cmpl_q, 2'b00, eerr_q, perr_q, 2'b00, ~busy_q};
  wire can_start = ~busy_q & ~eerr_q & ~perr_q;
  wire start = cs_rise & (act_q != SFCI_ACT_NONE) & can_start &
               ((act_q != SFCI_ACT_PROG) | (pcnt_q != 8'h00));
  wire done = busy_q & (tmr_q == 32'h0);
  wire [31:0] run_cyc = (act_q == SFCI_ACT_PROG) ? PROG_CYC : ERASE_CYC;
  wire [20:0] op_addr = (act_q == SFCI_ACT_SECT) ? {seg_q[11:4], 13'h0} :
                        (act_q == SFCI_ACT_PROG) ? {seg_q, ctr_q[8:7], 7'h0} :
                        21'h0;

  // Decoder next state; status and identity stay legal while busy
  always_comb begin
    st_d = st_q;
    if (cs_s) begin
      st_d = SFCI_IDLE;
    end else if (cs_fall) begin
      st_d = SFCI_CMD;
    end else if (byte_done) begin
      case (st_q)
        SFCI_CMD: begin
          case (in_byte)
            `SFCI_OP_READ: st_d = SFCI_ADDR;
            `SFCI_OP_STAT: st_d = SFCI_STAT;
            `SFCI_OP_CLR: st_d = SFCI_WAIT;
            `SFCI_OP_ID: st_d = SFCI_DUMMY;
            `SFCI_OP_SECT: st_d = SFCI_ADDR;
            `SFCI_OP_CHIP: st_d = SFCI_WAIT;
            `SFCI_OP_PROG: st_d = SFCI_ADDR;
            default: st_d = SFCI_IGNORE;
          endcase
        end
        SFCI_ADDR: begin
          if (addr_last) begin
            st_d = (op_q == `SFCI_OP_READ) ? SFCI_DUMMY :
                   (op_q == `SFCI_OP_PROG) ? SFCI_LOAD : SFCI_WAIT;
          end
        end
        SFCI_DUMMY: begin
          if (dummy_last) begin
            st_d = (op_q == `SFCI_OP_ID) ? SFCI_IDOUT : SFCI_ARR;
          end
        end
        default: st_d = st_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      st_q <= SFCI_IDLE;
      cnt_q <= 3'h0;
      bidx_q <= 3'h0;
      in_sh_q <= 8'h00;
      op_q <= 8'h00;
    end else begin
      cs_q <= cs_s;
      sclk_q <= sclk_s;
      st_q <= st_d;
      if (cs_s | cs_fall) begin
        cnt_q <= 3'h0;
      end else if (rise) begin
        cnt_q <= cnt_q + 3'h1;
        in_sh_q <= in_byte;
      end
      if (in_cmd) begin
        op_q <= in_byte;
      end
      if (cs_fall | (byte_done & (st_d != st_q))) begin
        bidx_q <= 3'h0;
      end else if (byte_done) begin
        bidx_q <= bidx_q + 3'h1;
      end
    end
  end

  // Address capture, read counter and page buffer
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      seg_q <= 12'h0;
      ctr_q <= 9'h0;
      pcnt_q <= 8'h00;
      arr_addr_o <= 21'h0;
    end else begin
      arr_addr_o <= {seg_q, ctr_q};
      if (cs_fall) begin
        pcnt_q <= 8'h00;
      end
      if (byte_done & (st_q == SFCI_ADDR)) begin
        case (bidx_q)
          3'h0: seg_q[11:8] <= in_byte[3:0];
          3'h1: seg_q[7:0] <= in_byte;
          3'h2: ctr_q[8:7] <= in_byte[1:0];
          default: ctr_q[6:0] <= in_byte[6:0];
        endcase
      end else if ((st_q == SFCI_ARR & byte_done) | (dummy_last & op_q == `SFCI_OP_READ)) begin
        ctr_q <= ctr_q + 9'h1;
      end else if (byte_done & (st_q == SFCI_LOAD)) begin
        ctr_q[6:0] <= ctr_q[6:0] + 7'h1;
        if (pcnt_q != `SFCI_PAGE_BYTES) begin
          pcnt_q <= pcnt_q + 8'h01;
        end
      end
    end
  end

  // Buffer storage is written only while loading, so no reset is needed
  always_ff @(posedge ref_clk_i) begin
    if (byte_done & (st_q == SFCI_LOAD)) begin
      pbuf_q[ctr_q[6:0]] <= in_byte;
    end
    pbuf_byte_o <= pbuf_q[pbuf_idx_i];
  end

  // Output shifter: a byte is loaded on the edge that ends the previous byte
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      out_sh_q <= 8'h00;
      id_sel_q <= 1'b0;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_oe_o <= ~cs_s & out_st;
      if (in_cmd & (in_byte == `SFCI_OP_STAT)) begin
        out_sh_q <= status;
      end else if (dummy_last) begin
        out_sh_q <= (op_q == `SFCI_OP_ID) ? `SFCI_MFR_CODE : arr_data_i;
        id_sel_q <= 1'b1;
      end else if (byte_done & out_st) begin
        case (st_q)
          SFCI_STAT: out_sh_q <= status;
          SFCI_IDOUT: out_sh_q <= id_sel_q ? `SFCI_DEV_CODE : `SFCI_MFR_CODE;
          default: out_sh_q <= arr_data_i;
        endcase
        id_sel_q <= ~id_sel_q;
      end else if (rise & out_st) begin
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
      if (cs_s) begin
        so_o <= 1'b0;
      end else if (rise & out_st) begin
        so_o <= out_sh_q[7];
      end
    end
  end

  // Status and operation timing; a completion beats a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      act_q <= SFCI_ACT_NONE;
      busy_q <= 1'b0;
      cmpl_q <= 1'b1;
      eerr_q <= 1'b0;
      perr_q <= 1'b0;
      tmr_q <= 32'h0;
      op_start_o <= 1'b0;
      op_kind_o <= SFCI_ACT_NONE;
      op_addr_o <= 21'h0;
      op_len_o <= 8'h00;
      status_o <= `SFCI_STAT_RST;
    end else begin
      status_o <= status;
      op_start_o <= start;
      if (cs_fall) begin
        act_q <= SFCI_ACT_NONE;
      end else if (in_cmd & (in_byte == `SFCI_OP_CHIP)) begin
        act_q <= SFCI_ACT_CHIP;
      end else if (addr_last) begin
        act_q <= (op_q == `SFCI_OP_SECT) ? SFCI_ACT_SECT :
                 (op_q == `SFCI_OP_PROG) ? SFCI_ACT_PROG : SFCI_ACT_NONE;
      end
      if (start) begin
        busy_q <= 1'b1;
        tmr_q <= run_cyc - 32'h1;
        op_kind_o <= act_q;
        op_addr_o <= op_addr;
        op_len_o <= pcnt_q;
      end else if (done) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        tmr_q <= tmr_q - 32'h1;
      end
      if (done) begin
        cmpl_q <= 1'b0;
      end else if (start | clear_cmd) begin
        cmpl_q <= 1'b1;
      end
      if (done & op_fail_i & (op_kind_o != SFCI_ACT_PROG)) begin
        eerr_q <= 1'b1;
      end else if (clear_cmd) begin
        eerr_q <= 1'b0;
      end
      if (done & op_fail_i & (op_kind_o == SFCI_ACT_PROG)) begin
        perr_q <= 1'b1;
      end else if (clear_cmd) begin
        perr_q <= 1'b0;
      end
    end
  end

  sequence s_stat_cmd;
    in_cmd && in_byte == `SFCI_OP_STAT;
  endsequence
  sequence s_stat_out;
    st_q == SFCI_STAT && out_sh_q == $past(status);
  endsequence

  a_cs_high_quiet: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cs_s |=> !so_oe_o)
    else $error("serial output enabled while deselected");
  a_ignore_quiet: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    st_q == SFCI_IGNORE |=> !so_oe_o)
    else $error("serial output enabled after unknown command");
  a_stat_decode: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_stat_cmd |=> s_stat_out)
    else $error("status opcode did not load the status byte");
  a_err_blocks: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (eerr_q || perr_q) && cs_rise |=> !op_start_o ##1 !busy_q)
    else $error("operation started with an error flag set");
  a_busy_report: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    op_start_o |-> busy_q ##1 !status_o[`SFCI_ST_RDY])
    else $error("ready bit not low after operation start");
  a_busy_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(busy_q) |-> busy_q[*8])
    else $error("busy dropped too early");
  a_cmpl_fall: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(cmpl_q) |-> $past(done))
    else $error("completion bit fell without a completion");
  a_clear_errs: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    clear_cmd && !done |=> !eerr_q && !perr_q && cmpl_q)
    else $error("clear command left an error bit set");
  a_seg_wrap: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    st_q == SFCI_ARR && byte_done && ctr_q == 9'h1ff |=> ctr_q == 9'h0 && $stable(seg_q))
    else $error("read counter left its segment");
  a_reset_stat: assert property (@(posedge ref_clk_i)
    !$past(resetn_i) && resetn_i |-> status == `SFCI_STAT_RST)
    else $error("status wrong after reset");
endmodule

/* hw/sfci_params.svh */
// Constants of the serial flash command interface: opcodes, status layout, timing.
// Assumes nothing; included by the top design file and the bench.
`ifndef SFCI_PARAMS_SVH
`define SFCI_PARAMS_SVH
`define SFCI_OP_READ 8'h52
`define SFCI_OP_STAT 8'h83
`define SFCI_OP_CLR 8'h89
`define SFCI_OP_ID 8'h85
`define SFCI_OP_SECT 8'hf1
`define SFCI_OP_CHIP 8'hf4
`define SFCI_OP_PROG 8'hf2
`define SFCI_ST_CMPL 7
`define SFCI_ST_EERR 4
`define SFCI_ST_PERR 3
`define SFCI_ST_RDY 0
`define SFCI_STAT_RST 8'h81
`define SFCI_ADDR_BYTES 3'h4
`define SFCI_SECT_BYTES 3'h2
`define SFCI_RD_DUMMY 3'h4
`define SFCI_ID_DUMMY 3'h1
`define SFCI_CLK_KHZ 125000
`define SFCI_ERASE_MS 300
`define SFCI_PROG_MS 5
`define SFCI_PAGE_BYTES 8'h80
// Identity codes: arbitrary values
`define SFCI_MFR_CODE 8'h5a
`define SFCI_DEV_CODE 8'h3c
`endif

/* hw/sfci_pkg.sv */
// Types of the serial flash command interface.
// Assumes sfci_params.svh holds the numeric constants.
package sfci_pkg;
  typedef enum logic [3:0] {
    SFCI_IDLE = 4'h0,
    SFCI_CMD = 4'h1,
    SFCI_ADDR = 4'h2,
    SFCI_DUMMY = 4'h3,
    SFCI_ARR = 4'h4,
    SFCI_STAT = 4'h5,
    SFCI_IDOUT = 4'h6,
    SFCI_LOAD = 4'h7,
    SFCI_WAIT = 4'h8,
    SFCI_IGNORE = 4'h9
  } sfci_state_t;
  typedef enum logic [1:0] {
    SFCI_ACT_NONE = 2'h0,
    SFCI_ACT_SECT = 2'h1,
    SFCI_ACT_CHIP = 2'h2,
    SFCI_ACT_PROG = 2'h3
  } sfci_act_t;
endpackage

/* hw/sfci_sync.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ns
module sfci_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_q <= RST;
      q_o <= RST;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

/* testbench/sfci_host.sv */
// Host side of the serial link: a plain SPI master with chip select.
// Assumes the bench calls its tasks one at a time; clk_i is the bench clock.
`timescale 1ns/1ns
module sfci_host (
  // Bench clock
  input wire logic clk_i,
  // Device answer
  input wire logic so_i,
  input wire logic so_oe_i,
  // Serial pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic sel();
    cs_n_o = 1'b0;
    wt(4);
  endtask

  // Released data line shows the inverse of its last bit, never a stale copy
  task automatic desel();
    cs_n_o = 1'b1;
    si_o = ~si_o;
    wt(6);
  endtask

  // One byte both ways; answer bits sampled just before the next rise, the last one three cycles after the final fall
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx, output logic [6:0] oe);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      si_o = tx[i];
      wt(4);
      if (i < 7) begin
        rx[i+1] = so_i;
        oe[i] = so_oe_i;
      end
      sclk_o = 1'b1;
      wt(4);
    end
    sclk_o = 1'b0;
    wt(3);
    rx[0] = so_i;
  endtask
endmodule

/* testbench/sfci_top_tb.sv */
// Self-checking bench for the serial flash command interface.
// Assumes sfci_host drives the pins; array and sequencer are modelled here.
`timescale 1ns/1ns
`include "sfci_params.svh"
`define TB_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module sfci_top_tb;
  import sfci_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sclk, si, so, so_oe, op_start;
  logic op_fail = 1'b0;
  logic [20:0] arr_addr, op_addr, addr_c;
  logic [7:0] arr_data = 8'h00;
  logic [7:0] pbuf_byte, status, op_len, len_c;
  logic [6:0] pbuf_idx = 7'h00;
  sfci_act_t op_kind, kind_c;
  int n_fail = 0;
  int n_compared = 0;
  int n_op = 0;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];

  // Short run counts keep erase and program in the hundreds of cycles
  sfci_top #(.ERASE_CYC(600), .PROG_CYC(200)) dut (
    .ref_clk_i(clk), .resetn_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .arr_addr_o(arr_addr), .arr_data_i(arr_data),
    .op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr), .op_len_o(op_len),
    .op_fail_i(op_fail), .pbuf_idx_i(pbuf_idx), .pbuf_byte_o(pbuf_byte), .status_o(status));
  sfci_host host (.clk_i(clk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sclk_o(sclk),
    .si_o(si));

  initial begin
    forever #4 clk = ~clk;
  end

  // Array contents depend on every address bit, so a wrong wrap shows up
  function automatic logic [7:0] af(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {a[20:16], 3'h0};
  endfunction

  always @(negedge clk) begin
    arr_data <= af(arr_addr);
  end

  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      n_op <= n_op + 1;
      kind_c <= op_kind;
      addr_c <= op_addr;
      len_c <= op_len;
    end
  end

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  task automatic run(input int nrd, input logic oe_x);
    logic [7:0] r;
    logic [6:0] oe;
    rxq = {};
    host.sel();
    foreach (txq[i]) begin
      host.xb(txq[i], r, oe);
      if (i < 5) `TB_CHK("input enable", 7'h00, oe)
    end
    for (int k = 0; k < nrd; k++) begin
      host.xb(8'h00, r, oe);
      `TB_CHK("output enable", {7{oe_x}}, oe)
      rxq.push_back(r);
    end
    host.desel();
  endtask

  task automatic wait_op(input int exp);
    int t = 0;
    while (n_op != exp) begin
      t++;
      if (t > 60) begin
        n_fail++;
        print_verdict();
      end
      @(negedge clk);
    end
  endtask

  task automatic wait_rdy();
    int t = 0;
    while (status[0] !== 1'b1) begin
      t++;
      if (t > 2000) begin
        n_fail++;
        print_verdict();
      end
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
  endtask

  task automatic clr();
    txq = '{8'h89};
    run(0, 1'b1);
    repeat (4) @(negedge clk);
    `TB_CHK("cleared status", 8'h81, status)
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `TB_CHK("reset status", 8'h81, status)
    `TB_CHK("reset enable", 1'b0, so_oe)
    txq = '{8'h83};
    run(3, 1'b1);
    foreach (rxq[i]) `TB_CHK("status byte", 8'h81, rxq[i])
    txq = '{8'h85, 8'h00};
    run(3, 1'b1);
    `TB_CHK("maker code", `SFCI_MFR_CODE, rxq[0])
    `TB_CHK("part code", `SFCI_DEV_CODE, rxq[1])
    $display("test status and identity done");
    txq = '{8'h3a};
    run(2, 1'b0);
    txq = '{8'h83};
    run(1, 1'b1);
    `TB_CHK("status after junk", 8'h81, rxq[0])
    $display("test unknown command done");
    op_fail = 1'b1;
    txq = '{8'hf2, 8'hf1, 8'h02, 8'h03, 8'hfe, 8'hd0, 8'hd1, 8'hd2};
    run(0, 1'b1);
    wait_op(1);
    repeat (3) @(negedge clk);
    `TB_CHK("busy status", 8'h80, status)
    `TB_CHK("program kind", SFCI_ACT_PROG, kind_c)
    `TB_CHK("page base", {4'h1, 8'h02, 2'h3, 7'h00}, addr_c)
    `TB_CHK("page count", 8'h03, len_c)
    // Loading began at 7e, so the third byte must land at index 0
    for (int k = 0; k < 3; k++) begin
      pbuf_idx = 7'h7e + 7'(k);
      repeat (2) @(negedge clk);
      `TB_CHK("page byte", 8'hd0 + 8'(k), pbuf_byte)
    end
    wait_rdy();
    `TB_CHK("program error", 8'h09, status)
    op_fail = 1'b0;
    txq = '{8'hf4, 8'h00, 8'h00};
    run(0, 1'b1);
    repeat (60) @(negedge clk);
    `TB_CHK("refused start", 1, n_op)
    `TB_CHK("refused status", 8'h09, status)
    clr();
    $display("test program error done");
    op_fail = 1'b1;
    txq = '{8'hf4, 8'h00, 8'h00};
    run(0, 1'b1);
    wait_op(2);
    `TB_CHK("chip kind", SFCI_ACT_CHIP, kind_c)
    `TB_CHK("chip base", 21'h000000, addr_c)
    wait_rdy();
    `TB_CHK("erase error", 8'h11, status)
    clr();
    op_fail = 1'b0;
    txq = '{8'hf1, 8'hfa, 8'h5c};
    run(0, 1'b1);
    wait_op(3);
    `TB_CHK("sector kind", SFCI_ACT_SECT, kind_c)
    `TB_CHK("sector base", {4'ha, 4'h5, 13'h0000}, addr_c)
    txq = '{8'h83};
    run(1, 1'b1);
    `TB_CHK("status while busy", 8'h80, rxq[0])
    txq = '{8'h85, 8'h00};
    run(1, 1'b1);
    `TB_CHK("code while busy", `SFCI_MFR_CODE, rxq[0])
    wait_rdy();
    `TB_CHK("erase done", 8'h01, status)
    $display("test erase done");
    // Start two bytes before the segment end to cross the wrap
    txq = '{8'h52, 8'hf5, 8'ha3, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00};
    run(4, 1'b1);
    for (int k = 0; k < 4; k++) begin
      `TB_CHK("array byte", af({4'h5, 8'ha3, 9'(9'h1fe + k)}), rxq[k])
    end
    `TB_CHK("status kept", 8'h01, status)
    $display("test array read done");
    print_verdict();
  end
endmodule
